//--- src/cmd_fsm_defs.vh
// command-layer constants for the pio write / dma read state machines
// assumes inclusion by bare name from the design file
`ifndef CMD_FSM_DEFS_VH
`define CMD_FSM_DEFS_VH
// state codes
`define ST_IDLE        3'h0
`define ST_PIO_PREP    3'h1
`define ST_PIO_SETUP   3'h2
`define ST_PIO_RECV    3'h3
`define ST_PIO_STATUS  3'h4
`define ST_DMA_PREP    3'h5
`define ST_DMA_SEND    3'h6
`define ST_DMA_STATUS  3'h7
// frame kinds requested from the transport layer
`define FRAME_NONE     2'h0
`define FRAME_SETUP    2'h1
`define FRAME_DATA     2'h2
`define FRAME_REG      2'h3
// command classes
`define CMD_PIO_WRITE  1'b0
`define CMD_DMA_READ   1'b1
// largest dma read data frame payload in bytes
`define DMA_MAX_BYTES  14'h2000
`endif

//--- src/dev_pio_out_dma_in_cmd_fsm.v
// device command layer: pio write and dma read protocol state machines
// assumes the transport layer answers each frame request with a one-cycle done pulse
// assumes every input comes from logic on the same clock, so none is synchronised
// assumes the caller counts blocks and raises all-done or abort as a level
// status register content beyond the interrupt bit and the setup frame busy and data request bits is built outside this block
// What this block does
// - write-class commands use pio host-to-device protocol, moving data blocks in
// - write command or more blocks needed enters preparation state
// - once ready for a block, go send a pio setup frame
// - all blocks received or error abort goes to write status state
// - setup frame initial status: busy clear, data request set
// - interrupt bit clear in first block setup frame, set in later ones
// - setup frame ending status: busy set, data request clear
// - setup frame carries the byte count of the expected block
// - after setup frame sent, receive the requested data frame
// - data frame received returns to write preparation
// - write status sends register frame with interrupt set, then idle
// - dma read commands move data blocks to host by dma
// - read data ready moves from read preparation to data send
// - all read data sent or error abort goes to read status
// - each read data frame payload is at most 8KB
// - each read data frame sent returns to read preparation
// - read status sends register frame with interrupt set, then idle
`timescale 1ns/10ps
`default_nettype none
`include "cmd_fsm_defs.vh"
module dev_pio_out_dma_in_cmd_fsm #(
  parameter CNT_W = 14
) (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_cmd_valid,
  input wire i_cmd_class,
  input wire i_blk_ready,
  input wire [CNT_W-1:0] i_blk_bytes,
  input wire i_all_done,
  input wire i_abort,
  input wire i_tl_done,
  input wire i_data_rx,
  output reg o_cmd_busy,
  output reg [1:0] o_frame_req,
  output reg [CNT_W-1:0] o_frame_bytes,
  output reg o_irq_bit,
  output reg o_init_busy,
  output reg o_init_drq,
  output reg o_end_busy,
  output reg o_end_drq,
  output reg o_recv_en,
  output reg [2:0] o_state
);


  // state codes, one per protocol state
  localparam [2:0] device_idle_state = `ST_IDLE;
  // write command states
  localparam [2:0] pio_write_prepare_state = `ST_PIO_PREP;
  localparam [2:0] pio_write_setup_send_state = `ST_PIO_SETUP;
  localparam [2:0] pio_write_receive_state = `ST_PIO_RECV;
  localparam [2:0] pio_write_status_state = `ST_PIO_STATUS;
  // read command states
  localparam [2:0] dma_read_prepare_state = `ST_DMA_PREP;
  localparam [2:0] dma_read_data_send_state = `ST_DMA_SEND;
  localparam [2:0] dma_read_status_state = `ST_DMA_STATUS;

  // largest dma read payload at the width of the byte count
  localparam [CNT_W-1:0] max_dma_bytes = `DMA_MAX_BYTES;

  // current and next protocol state
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  // first write block of the running command still to be received
  reg first_blk_r;
  reg first_blk_nxt;
  // state changes on this edge, so a fresh frame request starts
  wire new_frame_w;

  // limit requested byte count to the dma frame ceiling
  // a larger count would overrun the transport layer's frame limit
  function [CNT_W-1:0] clip_bytes;
    input [CNT_W-1:0] b;
    begin
      if (b > max_dma_bytes)
        clip_bytes = max_dma_bytes;
      else
        clip_bytes = b;
    end
  endfunction

  // true in either status state, where a register frame goes out
  function is_status;
    input [2:0] s;
    begin
      is_status = (s == pio_write_status_state) || (s == dma_read_status_state);
    end
  endfunction

  // true while a write-block setup frame is requested
  function is_setup;
    input [2:0] s;
    begin
      is_setup = (s == pio_write_setup_send_state);
    end
  endfunction

  // frame kind that the transport layer is asked to move in a state
  function [1:0] frame_of;
    input [2:0] s;
    begin
      if (is_setup(s))
        frame_of = `FRAME_SETUP;
      else if (s == dma_read_data_send_state)
        frame_of = `FRAME_DATA;
      else if (is_status(s))
        frame_of = `FRAME_REG;
      else
        frame_of = `FRAME_NONE;
    end
  endfunction

  // next-state logic for both command classes
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      device_idle_state:
      begin
        // a new command is only taken while idle
        if (i_cmd_valid)
        begin
          if (i_cmd_class == `CMD_PIO_WRITE)
            state_nxt = pio_write_prepare_state;
          else
            state_nxt = dma_read_prepare_state;
        end
      end
      pio_write_prepare_state:
      begin
        // finishing or aborting wins over a ready block
        if (i_all_done || i_abort)
          state_nxt = pio_write_status_state;
        else if (i_blk_ready)
          state_nxt = pio_write_setup_send_state;
      end
      pio_write_setup_send_state:
      begin
        // wait for the transport layer to report the setup frame sent
        if (i_tl_done)
          state_nxt = pio_write_receive_state;
      end
      pio_write_receive_state:
      begin
        // only the data-received strobe ends the receive window
        if (i_data_rx)
          state_nxt = pio_write_prepare_state;
      end
      pio_write_status_state:
      begin
        // register frame with interrupt set, then back to idle
        if (i_tl_done)
          state_nxt = device_idle_state;
      end
      dma_read_prepare_state:
      begin
        // finishing or aborting wins over ready data
        if (i_all_done || i_abort)
          state_nxt = dma_read_status_state;
        else if (i_blk_ready)
          state_nxt = dma_read_data_send_state;
      end
      dma_read_data_send_state:
      begin
        // one data frame per visit, then prepare the next
        if (i_tl_done)
          state_nxt = dma_read_prepare_state;
      end
      dma_read_status_state:
      begin
        // register frame with interrupt set, then back to idle
        if (i_tl_done)
          state_nxt = device_idle_state;
      end
      default:
        // unused code: recover to idle
        state_nxt = device_idle_state;
    endcase
  end

  // first-block marker: set while idle, cleared once a write block lands
  // only the receive state clears it, so a stray strobe elsewhere is harmless
  always @*
  begin
    first_blk_nxt = first_blk_r;
    if (state_r == device_idle_state)
      first_blk_nxt = 1'b1;
    else if (state_r == pio_write_receive_state && i_data_rx)
      first_blk_nxt = 1'b0;
  end

  // a request starts whenever the state moves
  assign new_frame_w = (state_nxt != state_r);

  // state and first-block registers
  always @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      state_r <= device_idle_state;
      first_blk_r <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      first_blk_r <= first_blk_nxt;
    end
  end

  // state mirror taken from the next state
  always @(posedge i_sys_clk)
  begin
    if (i_rst)
      o_state <= device_idle_state;
    else
      o_state <= state_nxt;
  end

  // busy flag, high from command taken until back in idle
  always @(posedge i_sys_clk)
  begin
    if (i_rst)
      o_cmd_busy <= 1'b0;
    else
      o_cmd_busy <= (state_nxt != device_idle_state);
  end

  // receive window for the write data frame
  always @(posedge i_sys_clk)
  begin
    if (i_rst)
      o_recv_en <= 1'b0;
    else
      o_recv_en <= (state_nxt == pio_write_receive_state);
  end

  // frame request towards the transport layer, held until it reports done
  always @(posedge i_sys_clk)
  begin
    if (i_rst)
      o_frame_req <= `FRAME_NONE;
    else
      o_frame_req <= frame_of(state_nxt);
  end

  // initial status of a setup frame: busy clear, data request set
  always @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      o_init_busy <= 1'b0;
      o_init_drq <= 1'b0;
    end
    else
    begin
      o_init_busy <= 1'b0;
      o_init_drq <= is_setup(state_nxt);
    end
  end

  // ending status of a setup frame: busy set, data request clear
  always @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      o_end_busy <= 1'b0;
      o_end_drq <= 1'b0;
    end
    else
    begin
      o_end_busy <= is_setup(state_nxt);
      o_end_drq <= 1'b0;
    end
  end

  // interrupt bit: clear on the first setup frame, set on later ones and on status
  always @(posedge i_sys_clk)
  begin
    if (i_rst)
      o_irq_bit <= 1'b0;
    else if (is_setup(state_nxt))
      o_irq_bit <= ~first_blk_nxt;
    else if (is_status(state_nxt))
      o_irq_bit <= 1'b1;
    else
      o_irq_bit <= 1'b0;
  end

  // byte count sampled on the edge that enters setup or data send, then held
  always @(posedge i_sys_clk)
  begin
    if (i_rst)
      o_frame_bytes <= {CNT_W{1'b0}};
    else if (new_frame_w && is_setup(state_nxt))
      o_frame_bytes <= i_blk_bytes;
    else if (new_frame_w && state_nxt == dma_read_data_send_state)
      o_frame_bytes <= clip_bytes(i_blk_bytes);
  end

endmodule // dev_pio_out_dma_in_cmd_fsm
`default_nettype wire

//--- verification/cmd_fsm_chk.sv
// checker: command state machine port relations
// assumes bind onto the design top
`timescale 1ns/10ps
`default_nettype none
module cmd_fsm_chk #(parameter CNT_W = 14) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_all_done,
  input wire logic i_tl_done,
  input wire logic i_data_rx,
  input wire logic [1:0] o_frame_req,
  input wire logic [CNT_W-1:0] o_frame_bytes,
  input wire logic o_irq_bit,
  input wire logic o_init_busy,
  input wire logic o_init_drq,
  input wire logic o_end_busy,
  input wire logic o_end_drq,
  input wire logic [2:0] o_state
);
  // all checks on the rising edge, off in reset
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  a_prep_end: assert property (o_state==3'h1&&i_all_done|=>o_state==3'h4) else $error("end");
  a_setup_recv: assert property (o_state==3'h2&&i_tl_done|=>o_state==3'h3) else $error("recv");
  a_recv_back: assert property (o_state==3'h3&&i_data_rx|=>o_state==3'h1) else $error("back");
  a_pio_idle: assert property (o_state==3'h4&&i_tl_done|=>o_state==3'h0) else $error("pio");
  a_send_back: assert property (o_state==3'h6&&i_tl_done|=>o_state==3'h5) else $error("send");
  a_dma_idle: assert property (o_state==3'h7&&i_tl_done|=>o_state==3'h0) else $error("dma");
  a_dma_clip: assert property (o_state==3'h6|->o_frame_bytes<=14'h2000) else $error("size");
  a_reg_irq: assert property (o_frame_req==2'h3|->o_irq_bit) else $error("irq");
  a_setup_status: assert property (o_frame_req==2'h1|->{o_init_busy,o_init_drq,o_end_busy,o_end_drq}==4'h6) else $error("st");
endmodule // cmd_fsm_chk
bind dev_pio_out_dma_in_cmd_fsm cmd_fsm_chk #(.CNT_W(CNT_W)) i_cmd_fsm_chk (.*);
`default_nettype wire

//--- verification/tl_model.sv
// transport model: one pulse a set latency after each request
// assumes design outputs settle after the rising edge
`timescale 1ns/10ps
`default_nettype none
module tl_model (
  input wire logic i_clk,
  input wire logic [1:0] i_req,
  input wire logic i_rx_en,
  input wire logic [3:0] i_lat,
  output var logic o_done = 1'h0,
  output var logic o_rx = 1'h0
);
  logic [3:0] n_r = 4'h0;
  // count the latency, pulse once, then clear
  always @(negedge i_clk)
    if (o_done||o_rx||(i_req==2'h0&&!i_rx_en))
    begin
      n_r <= 4'h0;
      o_done <= 1'h0;
      o_rx <= 1'h0;
    end
    else if (n_r==i_lat)
    begin
      o_done <= i_req!=2'h0;
      o_rx <= i_rx_en;
    end
    else
      n_r <= n_r+4'h1;
endmodule // tl_model
`default_nettype wire

//--- verification/dev_pio_out_dma_in_cmd_fsm_test.sv
// bench: pio write and dma read command flows
// assumes the transport model answers every request
`timescale 1ns/10ps
`default_nettype none
`define CHK(a,b) begin n_checks++; if ((a)!==(b)) begin num_errors++; $display("ERROR %0t bad",$time); end end
module dev_pio_out_dma_in_cmd_fsm_test;
  logic i_sys_clk=1'h0, i_rst=1'h1, i_cmd_valid=1'h0, i_cmd_class=1'h0, i_blk_ready=1'h0;
  logic i_all_done=1'h0, i_abort=1'h0, i_tl_done, i_data_rx, o_cmd_busy, o_irq_bit, o_recv_en;
  logic o_init_busy, o_init_drq, o_end_busy, o_end_drq;
  logic [1:0] o_frame_req;
  logic [13:0] i_blk_bytes=14'h0, o_frame_bytes;
  logic [2:0] o_state;
  logic [3:0] lat=4'h0;
  int num_errors=0, n_checks=0;
  dev_pio_out_dma_in_cmd_fsm i_dev_pio_out_dma_in_cmd_fsm (.*);
  tl_model i_tl_model (.i_clk(i_sys_clk), .i_req(o_frame_req), .i_rx_en(o_recv_en), .i_lat(lat),
    .o_done(i_tl_done), .o_rx(i_data_rx));
  task final_report;
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors==0&&n_checks>0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // bounded wait for a state
  task ws(input logic [2:0] s);
    repeat (40) if (o_state!==s) @(negedge i_sys_clk);
    `CHK(o_state,s)
    if (o_state!==s) final_report();
  endtask
  task go(input logic c);
    i_cmd_class = c;
    i_cmd_valid = 1'h1;
    @(negedge i_sys_clk);
    i_cmd_valid = 1'h0;
  endtask
  // two blocks, then status
  task pio_write;
    i_blk_bytes = 14'h200;
    go(1'h0);
    ws(3'h1);
    i_blk_ready = 1'h1;
    ws(3'h2);
    `CHK({o_irq_bit,o_init_busy,o_init_drq,o_end_busy,o_end_drq,o_frame_bytes},{5'h6,14'h200})
    i_blk_ready = 1'h0;
    ws(3'h3);
    `CHK({o_recv_en,o_cmd_busy},2'h3)
    ws(3'h1);
    i_blk_bytes = 14'h400;
    i_blk_ready = 1'h1;
    ws(3'h2);
    `CHK({o_irq_bit,o_frame_bytes},{1'h1,14'h400})
    i_blk_ready = 1'h0;
    ws(3'h1);
    i_all_done = 1'h1;
    ws(3'h4);
    `CHK({o_frame_req,o_irq_bit},3'h7)
    i_all_done = 1'h0;
    ws(3'h0);
    `CHK({o_cmd_busy,o_frame_req,o_recv_en},4'h0)
  endtask
  // oversize frame, refused command, abort
  task dma_read;
    lat = 4'h3;
    i_blk_bytes = 14'h3000;
    go(1'h1);
    ws(3'h5);
    i_blk_ready = 1'h1;
    ws(3'h6);
    `CHK({o_frame_req,o_frame_bytes},{2'h2,14'h2000})
    i_blk_ready = 1'h0;
    ws(3'h5);
    go(1'h0);
    `CHK(o_state,3'h5)
    i_abort = 1'h1;
    ws(3'h7);
    `CHK({o_frame_req,o_irq_bit},3'h7)
    i_abort = 1'h0;
    ws(3'h0);
  endtask
  initial
  begin
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end
  // reset, scenarios, verdict
  initial
  begin
    repeat (6) @(negedge i_sys_clk);
    i_rst = 1'h0;
    pio_write();
    dma_read();
    final_report();
  end
endmodule // dev_pio_out_dma_in_cmd_fsm_test
`default_nettype wire
